// [common/lsf_pkg.sv]
// Purpose: Shared constants and types of the signalling decode control.
// Assumes: Lengths are bit counts, LEN_W bits wide.
// Notes: Field-length weights are plain defaults for the part extractor.
package lsf_pkg;
	localparam int LEN_W = 18;
	typedef logic [LEN_W-1:0] lsf_len_t;
	// Code dimensions (decimal 3240, 3072, 168, 7200, 7032, 16200, 32)
	localparam lsf_len_t PRE_KLDPC = 18'h00CA8;
	localparam lsf_len_t PRE_KBCH = 18'h00C00;
	localparam lsf_len_t BCH_PARITY = 18'h000A8;
	localparam lsf_len_t POST_KLDPC = 18'h01C20;
	localparam lsf_len_t POST_KBCH = 18'h01B78;
	localparam lsf_len_t NLDPC_SHORT = 18'h03F48;
	localparam lsf_len_t CRC_LEN = 18'h00020;
	// Configurable and dynamic part lengths
	localparam lsf_len_t CONF_FIXED = 18'h00023;
	localparam lsf_len_t CONF_PER_RF = 18'h00023;
	localparam lsf_len_t CONF_PER_PIPE = 18'h00059;
	localparam lsf_len_t CONF_PER_AUX = 18'h00020;
	localparam lsf_len_t CONF_FEF = 18'h00033;
	localparam lsf_len_t DYN_FIXED = 18'h00047;
	localparam lsf_len_t DYN_PER_PIPE = 18'h00030;
	localparam lsf_len_t DYN_PER_AUX = 18'h00030;
	// Descrambler sequence, restarted for every post block
	localparam logic [14:0] SCR_SEED = 15'h4A80;
	localparam logic [14:0] SCR_TAPS = 15'h0003;
	// Register byte offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_SEGMENT = 8'h08;
	localparam logic [7:0] REG_CODE = 8'h0C;
	localparam logic [7:0] REG_PARTS = 8'h10;
	// Field positions
	localparam int CTRL_START = 0;
	localparam int CTRL_AUTO = 1;
	localparam int ST_PREOK = 3;
	localparam int ST_FAIL = 4;
	localparam int ST_DONE = 5;
	localparam int ST_OVFL = 6;
	localparam int ST_REPEAT = 7;
	localparam logic CTRL_AUTO_RST = 1'b1;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_PRE_LDPC = 3'h1,
		ST_PRE_BCH = 3'h3,
		ST_DIVIDE = 3'h2,
		ST_POST_LDPC = 3'h6,
		ST_POST_BCH = 3'h7,
		ST_OUTPUT = 3'h5,
		ST_FAILED = 3'h4
	} lsf_state_t;
	typedef enum logic [1:0] {
		RG_CONF = 2'h0,
		RG_DYN = 2'h1,
		RG_NEXT_DYN = 2'h2,
		RG_EXT = 2'h3
	} lsf_region_t;
endpackage

// [rtl/lsf_cell_store.sv]
// Purpose: Single-port-per-side cell memory with registered read data.
// Assumes: One write and one read port on the same clock.
// Notes: Array itself is not reset; only the read register is.
`timescale 1ns/1ps
module lsf_cell_store #(
	parameter int W = 24,
	parameter int DEPTH = 32768,
	parameter int AW = $clog2(DEPTH)
) (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic wrEn,
	input wire logic [AW-1:0] wrAddr,
	input wire logic [W-1:0] wrData,
	input wire logic rdEn,
	input wire logic [AW-1:0] rdAddr,
	output logic [W-1:0] rdData
);
	logic [W-1:0] mem [DEPTH];

	always_ff @(posedge clock) begin
		if (wrEn) begin
			mem[wrAddr] <= wrData;
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			rdData <= '0;
		end else if (rdEn) begin
			rdData <= mem[rdAddr];
		end
	end
endmodule

// [rtl/lsf_decode_ctrl.sv]
// Purpose: Sequencer for signalling FEC decode, segmentation, descramble.
// Assumes: External LDPC/BCH engine driven through the fec* ports.
// Notes: Data symbols pass through the cell store; ones arriving while it is full are dropped.
`timescale 1ns/1ps
// What this block does
// - Signalling cells get no time or cell de-interleaving, zig-zag only.
// - Pre-signalling cells demapped as BPSK, one bit per cell.
// - Post bit de-interleave without column twist, no parity stage.
// - Pre decoded with short LDPC K=3240 then BCH K=3072.
// - BCH runs after LDPC, on info bits minus 168 parity bits.
// - Shortened bits known zero, punctured parity bits erasures.
// - Post code rate, modulation, frame length from pre fields.
// - Each post block: short LDPC K=7200 then BCH K=7032.
// - Unpadded post length is info-size field plus 32 CRC bits.
// - Above 7032 bits, post split into sequentially decoded segments.
// - Segment shortening and puncturing counts derived from info size.
// - Scrambled flag set: descramble every post block after FEC.
// - Pre-signalling bits are never descrambled.
// - Segments concatenated in order; coded length total over count.
// - Dynamic part follows configurable part; lengths from counts.
// - Repeat flag set: next-frame dynamic part follows current one.
// - Next-frame dynamic part flagged so it can be combined later.
// - Data symbols buffered until post parameters are extracted.
// - Inter-symbol storage sized at most one 32K-carrier symbol.
module lsf_decode_ctrl
	import lsf_pkg::*;
#(
	parameter int CELL_W = 24,
	parameter int LLR_W = 12,
	parameter int BUF_DEPTH = 32768
) (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic frameStart,
	input wire logic cellValid,
	input wire logic [LLR_W-1:0] cellI,
	output logic llrValid,
	output logic [LLR_W-1:0] llrOut,
	output logic fecStart,
	output logic fecIsBch,
	output logic fecIsPost,
	output logic [LEN_W-1:0] fecK,
	output logic [LEN_W-1:0] fecShorten,
	output logic [LEN_W-1:0] fecPuncture,
	output logic [2:0] fecCodeRate,
	output logic [3:0] fecBitsPerCell,
	output logic fecLongFrame,
	output logic deintColumnTwist,
	output logic deintParity,
	output logic deintTimeCell,
	input wire logic fecDone,
	input wire logic fecOk,
	input wire logic [2:0] postCodeRateField,
	input wire logic [3:0] postModulationField,
	input wire logic [1:0] postFecLengthField,
	input wire logic [LEN_W-1:0] postInfoSizeField,
	input wire logic [LEN_W-1:0] postTotalSizeField,
	input wire logic postScrambledFlag,
	input wire logic dynamicRepeatFlag,
	input wire logic [2:0] rfCount,
	input wire logic [7:0] pipeCount,
	input wire logic [3:0] auxCount,
	input wire logic foreignFrameUsed,
	input wire logic decBitValid,
	input wire logic decBit,
	output logic sigBitValid,
	output logic sigBit,
	output logic [1:0] sigRegion,
	output logic sigLast,
	output logic postReady,
	output logic postFail,
	input wire logic symValid,
	input wire logic [CELL_W-1:0] symIn,
	output logic symOutValid,
	output logic [CELL_W-1:0] symOut
);
	localparam int AW = $clog2(BUF_DEPTH);

	if (BUF_DEPTH > 32768 || BUF_DEPTH < 2 ||
			(1 << AW) != BUF_DEPTH) begin : g_bad_depth
		$error("BUF_DEPTH must be a power of two up to 32768");
	end

	function automatic lsf_len_t satSub(lsf_len_t a, lsf_len_t b);
		return (a > b) ? lsf_len_t'(a - b) : '0;
	endfunction

	function automatic logic [3:0] bitsOf(logic [3:0] m);
		case (m)
			4'h0: return 4'h2;
			4'h1: return 4'h4;
			4'h2: return 4'h6;
			default: return 4'h1;
		endcase
	endfunction

	lsf_state_t state_q;
	logic issued_q, autoStart_q, swStart_q;
	logic preOk_q, fail_q, done_q, ovfl_q;
	logic awReady_q, wReady_q, bValid_q, arReady_q, rValid_q;
	logic awHeld_q, wHeld_q;
	logic [7:0] awAddr_q;
	logic [31:0] wData_q, rData_q;
	logic [3:0] wStrb_q;
	logic [1:0] bResp_q, rResp_q;
	logic [2:0] codeRate_q;
	logic [3:0] modul_q;
	logic [1:0] fecLen_q;
	logic scr_q, rep_q;
	lsf_len_t kPost_q, total_q, confLen_q, dynLen_q;
	lsf_len_t divNum_q, divQuo_q, segK_q, coded_q, remain_q, curLen_q;
	lsf_len_t shorten_q, punct_q, outCnt_q, pos_q;
	logic [1:0] divPhase_q;
	logic [7:0] nSeg_q, segIdx_q;
	logic [14:0] lfsr_q;
	logic [AW-1:0] wrPtr_q, rdPtr_q;
	logic [AW:0] fill_q;
	logic llrValid_q, fecStart_q, fecIsBch_q, fecIsPost_q;
	lsf_len_t fecK_q;
	logic sigValid_q, sigBit_q, sigLast_q, postReady_q, symOutValid_q;
	lsf_region_t sigRegion_q;

	logic doWrite, startReq, fecIdle, bufWr, bufRd, bufFull;
	lsf_len_t divDen, curLenNow, dynEnd, nextEnd;
	lsf_region_t regionNow;
	logic scrBit;

	assign startReq = swStart_q || (autoStart_q && frameStart);
	assign fecIdle = !issued_q;
	assign doWrite = awHeld_q && wHeld_q && !bValid_q;
	assign divDen = (divPhase_q == 2'h0) ? POST_KBCH : lsf_len_t'(nSeg_q);
	assign curLenNow = (remain_q < segK_q) ? remain_q : segK_q;
	assign dynEnd = lsf_len_t'(confLen_q + dynLen_q);
	assign nextEnd = lsf_len_t'(dynEnd + dynLen_q);
	assign scrBit = lfsr_q[14] ^ lfsr_q[13];

	always_comb begin
		if (pos_q < confLen_q) begin
			regionNow = RG_CONF;
		end else if (pos_q < dynEnd) begin
			regionNow = RG_DYN;
		end else if (rep_q && pos_q < nextEnd) begin
			regionNow = RG_NEXT_DYN;
		end else begin
			regionNow = RG_EXT;
		end
	end

	// Write channel: address and data taken in either order
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			awReady_q <= 1'b1;
			wReady_q <= 1'b1;
			awHeld_q <= 1'b0;
			wHeld_q <= 1'b0;
			awAddr_q <= '0;
			wData_q <= '0;
			wStrb_q <= '0;
			bValid_q <= 1'b0;
			bResp_q <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid && awReady_q) begin
				awAddr_q <= s_axi_awaddr;
				awHeld_q <= 1'b1;
				awReady_q <= 1'b0;
			end
			if (s_axi_wvalid && wReady_q) begin
				wData_q <= s_axi_wdata;
				wStrb_q <= s_axi_wstrb;
				wHeld_q <= 1'b1;
				wReady_q <= 1'b0;
			end
			if (doWrite) begin
				awHeld_q <= 1'b0;
				wHeld_q <= 1'b0;
				bValid_q <= 1'b1;
				bResp_q <= (awAddr_q == REG_CTRL ||
					awAddr_q == REG_STATUS) ? RESP_OKAY : RESP_SLVERR;
			end
			if (bValid_q && s_axi_bready) begin
				bValid_q <= 1'b0;
				awReady_q <= 1'b1;
				wReady_q <= 1'b1;
			end
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			autoStart_q <= CTRL_AUTO_RST;
			swStart_q <= 1'b0;
		end else begin
			swStart_q <= 1'b0;
			if (doWrite && awAddr_q == REG_CTRL && wStrb_q[0]) begin
				swStart_q <= wData_q[CTRL_START];
				autoStart_q <= wData_q[CTRL_AUTO];
			end
		end
	end

	// Read channel, one cycle after the address is taken
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			arReady_q <= 1'b1;
			rValid_q <= 1'b0;
			rData_q <= '0;
			rResp_q <= RESP_OKAY;
		end else if (s_axi_arvalid && arReady_q) begin
			arReady_q <= 1'b0;
			rValid_q <= 1'b1;
			rResp_q <= RESP_OKAY;
			unique case (s_axi_araddr)
				REG_CTRL: rData_q <= {30'h0, autoStart_q, 1'b0};
				REG_STATUS: rData_q <= {24'h0, rep_q, ovfl_q, done_q,
					fail_q, preOk_q, state_q};
				REG_SEGMENT: rData_q <= {segK_q[15:0], 8'h0, nSeg_q};
				REG_CODE: rData_q <= {punct_q[15:0], shorten_q[15:0]};
				REG_PARTS: rData_q <= {dynLen_q[15:0], confLen_q[15:0]};
				default: begin
					rData_q <= '0;
					rResp_q <= RESP_SLVERR;
				end
			endcase
		end else if (rValid_q && s_axi_rready) begin
			rValid_q <= 1'b0;
			arReady_q <= 1'b1;
		end
	end

	// Decode sequencer
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			state_q <= ST_IDLE;
			issued_q <= 1'b0;
			fecStart_q <= 1'b0;
			fecIsBch_q <= 1'b0;
			fecIsPost_q <= 1'b0;
			fecK_q <= '0;
			preOk_q <= 1'b0;
			fail_q <= 1'b0;
			done_q <= 1'b0;
			postReady_q <= 1'b0;
			divPhase_q <= '0;
			divNum_q <= '0;
			divQuo_q <= '0;
			nSeg_q <= '0;
			segIdx_q <= '0;
			segK_q <= '0;
			coded_q <= '0;
			remain_q <= '0;
			curLen_q <= '0;
			shorten_q <= '0;
			punct_q <= '0;
		end else begin
			fecStart_q <= 1'b0;
			unique case (state_q)
				ST_IDLE, ST_FAILED: begin
					if (startReq) begin
						state_q <= ST_PRE_LDPC;
						preOk_q <= 1'b0;
						fail_q <= 1'b0;
						done_q <= 1'b0;
						postReady_q <= 1'b0;
					end
				end
				ST_PRE_LDPC, ST_PRE_BCH, ST_POST_LDPC, ST_POST_BCH: begin
					if (fecIdle) begin
						fecStart_q <= 1'b1;
						issued_q <= 1'b1;
						fecIsBch_q <= &state_q[1:0]; // BCH codes end in 11
						fecIsPost_q <= state_q[2];
						unique case (state_q)
							ST_PRE_LDPC: fecK_q <= PRE_KLDPC;
							ST_PRE_BCH: fecK_q <= PRE_KBCH;
							ST_POST_LDPC: fecK_q <= POST_KLDPC;
							default: fecK_q <= POST_KBCH;
						endcase
					end else if (fecDone) begin
						issued_q <= 1'b0;
						unique case (state_q)
							ST_PRE_LDPC: state_q <= ST_PRE_BCH;
							ST_PRE_BCH: begin
								if (fecOk) begin
									preOk_q <= 1'b1;
									state_q <= ST_DIVIDE;
									divPhase_q <= 2'h0;
									divNum_q <= lsf_len_t'(postInfoSizeField
										+ CRC_LEN);
									divQuo_q <= '0;
								end else begin
									state_q <= ST_FAILED;
									fail_q <= 1'b1;
								end
							end
							ST_POST_LDPC: state_q <= ST_POST_BCH;
							default: begin
								if (fecOk) begin
									state_q <= ST_OUTPUT;
								end else begin
									state_q <= ST_FAILED;
									fail_q <= 1'b1;
								end
							end
						endcase
					end
				end
				ST_DIVIDE: begin
					if (divPhase_q != 2'h2 && divNum_q != '0) begin
						divNum_q <= satSub(divNum_q, divDen);
						divQuo_q <= lsf_len_t'(divQuo_q + 1'b1);
					end else if (divPhase_q == 2'h2 && divNum_q >= divDen) begin
						divNum_q <= satSub(divNum_q, divDen);
						divQuo_q <= lsf_len_t'(divQuo_q + 1'b1);
					end else begin
						divQuo_q <= '0;
						unique case (divPhase_q)
							2'h0: begin
								nSeg_q <= divQuo_q[7:0];
								divNum_q <= kPost_q;
								divPhase_q <= 2'h1;
							end
							2'h1: begin
								segK_q <= divQuo_q;
								divNum_q <= total_q;
								divPhase_q <= 2'h2;
							end
							default: begin
								coded_q <= divQuo_q;
								remain_q <= kPost_q;
								segIdx_q <= '0;
								postReady_q <= 1'b1;
								state_q <= ST_POST_LDPC;
							end
						endcase
					end
				end
				ST_OUTPUT: begin
					if (decBitValid &&
							outCnt_q == lsf_len_t'(curLen_q - 1'b1)) begin
						remain_q <= satSub(remain_q, curLen_q);
						segIdx_q <= segIdx_q + 8'h01;
						if (segIdx_q == nSeg_q - 8'h01) begin
							state_q <= ST_IDLE;
							done_q <= 1'b1;
						end else begin
							state_q <= ST_POST_LDPC;
						end
					end
				end
			endcase
			// Per-segment shortening and puncturing counts
			if (state_q == ST_POST_LDPC && fecIdle) begin
				curLen_q <= curLenNow;
				shorten_q <= satSub(POST_KBCH, curLenNow);
				punct_q <= satSub(lsf_len_t'(NLDPC_SHORT + curLenNow),
					lsf_len_t'(POST_KBCH + coded_q));
			end
		end
	end

	// Pre fields are trusted only after a clean pre decode
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			codeRate_q <= '0;
			modul_q <= '0;
			fecLen_q <= '0;
			scr_q <= 1'b0;
			rep_q <= 1'b0;
			kPost_q <= '0;
			total_q <= '0;
			confLen_q <= '0;
			dynLen_q <= '0;
		end else if (state_q == ST_PRE_BCH && issued_q && fecDone
				&& fecOk) begin
			codeRate_q <= postCodeRateField;
			modul_q <= postModulationField;
			fecLen_q <= postFecLengthField;
			scr_q <= postScrambledFlag;
			rep_q <= dynamicRepeatFlag;
			kPost_q <= lsf_len_t'(postInfoSizeField + CRC_LEN);
			total_q <= postTotalSizeField;
			confLen_q <= lsf_len_t'(CONF_FIXED + rfCount * CONF_PER_RF
				+ pipeCount * CONF_PER_PIPE + auxCount * CONF_PER_AUX
				+ (foreignFrameUsed ? CONF_FEF : '0));
			dynLen_q <= lsf_len_t'(DYN_FIXED + pipeCount * DYN_PER_PIPE
				+ auxCount * DYN_PER_AUX);
		end
	end

	// Pre cells: BPSK, sign carries the single bit, no de-interleaver
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			llrValid_q <= 1'b0;
			llrOut <= '0;
		end else begin
			llrValid_q <= cellValid && state_q == ST_PRE_LDPC;
			if (cellValid) begin
				llrOut <= cellI;
			end
		end
	end

	// Post bit stream: descramble, concatenate, tag parts
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			lfsr_q <= SCR_SEED;
			outCnt_q <= '0;
			pos_q <= '0;
			sigValid_q <= 1'b0;
			sigBit_q <= 1'b0;
			sigLast_q <= 1'b0;
			sigRegion_q <= RG_CONF;
		end else begin
			sigValid_q <= 1'b0;
			sigLast_q <= 1'b0;
			if (state_q == ST_PRE_LDPC) begin
				pos_q <= '0;
			end
			if (state_q != ST_OUTPUT) begin
				lfsr_q <= SCR_SEED;
				outCnt_q <= '0;
			end else if (decBitValid) begin
				sigValid_q <= 1'b1;
				// Only post blocks reach here, pre bits never do
				sigBit_q <= decBit ^ (scr_q & scrBit);
				lfsr_q <= {lfsr_q[13:0], scrBit};
				sigRegion_q <= regionNow;
				pos_q <= lsf_len_t'(pos_q + 1'b1);
				outCnt_q <= lsf_len_t'(outCnt_q + 1'b1);
				sigLast_q <= outCnt_q == lsf_len_t'(curLen_q - 1'b1)
					&& segIdx_q == nSeg_q - 8'h01;
			end
		end
	end

	// Symbol store: holds data symbols while signalling decodes
	assign bufFull = fill_q[AW];
	assign bufWr = symValid && !bufFull;
	assign bufRd = fill_q != '0 && (state_q == ST_IDLE ||
		state_q == ST_FAILED || postReady_q);

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
			fill_q <= '0;
			symOutValid_q <= 1'b0;
			ovfl_q <= 1'b0;
		end else begin
			symOutValid_q <= bufRd;
			if (bufWr) begin
				wrPtr_q <= wrPtr_q + 1'b1;
			end
			if (bufRd) begin
				rdPtr_q <= rdPtr_q + 1'b1;
			end
			fill_q <= fill_q + (AW+1)'(bufWr) - (AW+1)'(bufRd);
			// Set wins over a same-cycle clear
			if (symValid && bufFull) begin
				ovfl_q <= 1'b1;
			end else if (doWrite && awAddr_q == REG_STATUS && wStrb_q[0]
					&& wData_q[ST_OVFL]) begin
				ovfl_q <= 1'b0;
			end
		end
	end

	lsf_cell_store #(.W(CELL_W), .DEPTH(BUF_DEPTH), .AW(AW)) u_store (
		.clock(clock),
		.reset_n(reset_n),
		.wrEn(bufWr),
		.wrAddr(wrPtr_q),
		.wrData(symIn),
		.rdEn(bufRd),
		.rdAddr(rdPtr_q),
		.rdData(symOut)
	);

	// Engine configuration registered every cycle; shortening and puncturing per segment
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			fecCodeRate <= '0;
			fecBitsPerCell <= 4'h1;
			fecLongFrame <= 1'b0;
			fecShorten <= '0;
			fecPuncture <= '0;
			deintColumnTwist <= 1'b0;
			deintParity <= 1'b0;
			deintTimeCell <= 1'b0;
		end else begin
			fecCodeRate <= codeRate_q;
			fecBitsPerCell <= fecIsPost_q ? bitsOf(modul_q) : 4'h1;
			fecLongFrame <= fecLen_q != 2'h0;
			fecShorten <= fecIsPost_q ? shorten_q : '0;
			fecPuncture <= fecIsPost_q ? punct_q : '0;
			deintColumnTwist <= 1'b0;
			deintParity <= 1'b0;
			deintTimeCell <= 1'b0;
		end
	end

	assign s_axi_awready = awReady_q;
	assign s_axi_wready = wReady_q;
	assign s_axi_bvalid = bValid_q;
	assign s_axi_bresp = bResp_q;
	assign s_axi_arready = arReady_q;
	assign s_axi_rvalid = rValid_q;
	assign s_axi_rdata = rData_q;
	assign s_axi_rresp = rResp_q;
	assign llrValid = llrValid_q;
	assign fecStart = fecStart_q;
	assign fecIsBch = fecIsBch_q;
	assign fecIsPost = fecIsPost_q;
	assign fecK = fecK_q;
	assign sigBitValid = sigValid_q;
	assign sigBit = sigBit_q;
	assign sigRegion = sigRegion_q;
	assign sigLast = sigLast_q;
	assign postReady = postReady_q;
	assign postFail = fail_q;
	assign symOutValid = symOutValid_q;
endmodule

// [tb/lsf_fec_model.sv]
// Purpose: Behavioural decode engine and cell source behind the sequencer.
// Assumes: One job at a time; dly sets the answer latency.
// Notes: fecOk and cellI are scrambled outside their sampling cycles.
`timescale 1ns/1ps
module lsf_fec_model (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic fecStart,
	input wire logic fecIsBch,
	input wire logic fecIsPost,
	input wire logic okIn,
	input wire logic [3:0] dly,
	output logic fecDone,
	output logic fecOk,
	output logic cellValid,
	output logic [11:0] cellI
);
	logic busy_q;
	logic [3:0] cnt_q;
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			busy_q <= 1'b0;
			cnt_q <= 4'h0;
			fecDone <= 1'b0;
			fecOk <= 1'b0;
			cellValid <= 1'b0;
			cellI <= 12'h000;
		end else begin
			fecDone <= 1'b0;
			fecOk <= !okIn;
			cellValid <= 1'b0;
			cellI <= cellI + 12'h0A5;
			if (fecStart) begin
				busy_q <= 1'b1;
				cnt_q <= dly;
			end else if (busy_q) begin
				// Cells only feed the pre LDPC job
				cellValid <= !fecIsPost && !fecIsBch;
				if (cnt_q == 4'h0) begin
					busy_q <= 1'b0;
					fecDone <= 1'b1;
					fecOk <= okIn;
				end else begin
					cnt_q <= cnt_q - 4'h1;
				end
			end
		end
	end
endmodule

// [tb/lsf_decode_ctrl_checker.sv]
// Purpose: Port-level timing checks of the decode sequencer.
// Assumes: Engine answers every job it is given.
// Notes: Bound from the bench top file.
`timescale 1ns/1ps
module lsf_decode_ctrl_checker
	import lsf_pkg::*;
(
	input wire logic clock,
	input wire logic reset_n,
	input wire logic fecStart,
	input wire logic fecIsBch,
	input wire logic fecIsPost,
	input wire logic [LEN_W-1:0] fecK,
	input wire logic [2:0] fecCodeRate,
	input wire logic [3:0] fecBitsPerCell,
	input wire logic deintColumnTwist,
	input wire logic deintParity,
	input wire logic deintTimeCell,
	input wire logic fecDone,
	input wire logic fecOk,
	input wire logic [2:0] postCodeRateField,
	input wire logic cellValid,
	input wire logic [11:0] cellI,
	input wire logic llrValid,
	input wire logic [11:0] llrOut,
	input wire logic postReady,
	input wire logic postFail
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);
	property p_no_deint;
		!(deintTimeCell || deintColumnTwist || deintParity);
	endproperty
	a_no_deint: assert property (p_no_deint)
		else $error("deinterleave stage enabled");
	property p_pre_k;
		fecStart && !fecIsPost |-> fecK == (fecIsBch ? PRE_KBCH : PRE_KLDPC);
	endproperty
	a_pre_k: assert property (p_pre_k)
		else $error("pre job length wrong");
	property p_post_k;
		fecStart && fecIsPost |-> fecK == (fecIsBch ? POST_KBCH : POST_KLDPC);
	endproperty
	a_post_k: assert property (p_post_k)
		else $error("post job length wrong");
	property p_pre_bpsk;
		fecStart && !fecIsPost |=> fecBitsPerCell == 4'h1;
	endproperty
	a_pre_bpsk: assert property (p_pre_bpsk)
		else $error("pre cells not one bit each");
	property p_bch_after;
		fecStart && fecIsBch |-> $past(fecDone, 2);
	endproperty
	a_bch_after: assert property (p_bch_after)
		else $error("BCH job not after LDPC done");
	property p_fail;
		fecDone && fecIsBch && !fecOk |-> ##[1:3] postFail;
	endproperty
	a_fail: assert property (p_fail)
		else $error("failure not reported");
	property p_post_gate;
		fecStart && fecIsPost |-> postReady && !postFail;
	endproperty
	a_post_gate: assert property (p_post_gate)
		else $error("post job without good pre");
	property p_rate;
		fecStart && fecIsPost |-> fecCodeRate == postCodeRateField;
	endproperty
	a_rate: assert property (p_rate)
		else $error("post code rate not from field");
	property p_llr;
		llrValid |-> $past(cellValid) && llrOut == $past(cellI);
	endproperty
	a_llr: assert property (p_llr)
		else $error("soft bit not from last cell");
endmodule

// [tb/test_lsf_decode_ctrl.sv]
// Purpose: Register and sequence tests of the decode sequencer.
// Assumes: Engine model answers each job after dly cycles.
// Notes: Divide step is slow, so only two decodes are run, the second without output bits.
`timescale 1ns/1ps
module test_lsf_decode_ctrl;
	import lsf_pkg::*;
	logic clock, reset_n;
	logic [7:0] s_axi_awaddr, s_axi_araddr, pipeCount;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb, fecBitsPerCell, postModulationField;
	logic [3:0] auxCount, dly;
	logic [1:0] s_axi_bresp, s_axi_rresp, postFecLengthField, sigRegion;
	logic frameStart, cellValid, llrValid, fecStart, fecIsBch, fecIsPost;
	logic fecLongFrame, deintColumnTwist, deintParity, deintTimeCell;
	logic fecDone, fecOk, okIn, postScrambledFlag, dynamicRepeatFlag;
	logic foreignFrameUsed, decBitValid, decBit, sigBitValid, sigBit;
	logic sigLast, postReady, postFail, symValid, symOutValid;
	logic [11:0] cellI, llrOut;
	logic [LEN_W-1:0] fecK, fecShorten, fecPuncture;
	logic [LEN_W-1:0] postInfoSizeField, postTotalSizeField;
	logic [2:0] fecCodeRate, postCodeRateField, rfCount;
	logic [23:0] symIn, symOut;
	logic [1:0] r;
	int n_mismatch, n_checks, nOut;
	lsf_decode_ctrl #(.BUF_DEPTH(16)) dut_u (.*);
	lsf_fec_model fec_u (.*);
	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end
	always @(posedge clock) if (symOutValid === 1'b1) nOut++;
	task automatic chk(input string n, input logic [31:0] e, g);
		n_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("unexpected %s: expected %h, seen %h", n, e, g);
		end
	endtask
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic rst;
		reset_n <= 1'b0;
		repeat (8) @(posedge clock);
		reset_n <= 1'b1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] rs);
		logic ah, wh, bh;
		@(posedge clock);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		forever begin
			// Sample mid-cycle so the edge decision never races the slave
			@(negedge clock);
			ah = s_axi_awvalid && s_axi_awready;
			wh = s_axi_wvalid && s_axi_wready;
			bh = s_axi_bvalid;
			rs = s_axi_bresp;
			@(posedge clock);
			if (ah) s_axi_awvalid <= 1'b0;
			if (wh) s_axi_wvalid <= 1'b0;
			if (bh) break;
		end
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, m,
		input logic [1:0] er);
		logic [31:0] d;
		logic [1:0] rs;
		logic ah, rh;
		@(posedge clock);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		forever begin
			@(negedge clock);
			ah = s_axi_arvalid && s_axi_arready;
			rh = s_axi_rvalid;
			d = s_axi_rdata;
			rs = s_axi_rresp;
			@(posedge clock);
			if (ah) s_axi_arvalid <= 1'b0;
			if (rh) break;
		end
		s_axi_rready <= 1'b0;
		chk("read data", e, d & m);
		chk("read resp", {30'h0, er}, {30'h0, rs});
	endtask
	task automatic dec(input logic [17:0] info, input logic [2:0] rf,
		input logic [7:0] pipe, input logic [3:0] aux, input logic fx,
		input logic [31:0] eSeg, eCode, eParts);
		postInfoSizeField <= info;
		rfCount <= rf;
		pipeCount <= pipe;
		auxCount <= aux;
		foreignFrameUsed <= fx;
		dynamicRepeatFlag <= fx;
		postScrambledFlag <= fx;
		dly <= fx ? 4'hF : 4'h1;
		wr(REG_CTRL, 32'h3, r);
		wait (fecStart === 1'b1);
		@(posedge clock);
		nOut = 0;
		repeat (4) begin
			symIn <= symIn + 24'h111111;
			symValid <= 1'b1;
			@(posedge clock);
		end
		symValid <= 1'b0;
		wait (postReady === 1'b1);
		chk("symbols before ready", 0, nOut);
		repeat (20) @(posedge clock);
		chk("symbols after ready", 4, nOut);
		rd(REG_SEGMENT, eSeg, 32'hFFFF00FF, RESP_OKAY);
		rd(REG_CODE, eCode, 32'hFFFFFFFF, RESP_OKAY);
		rd(REG_PARTS, eParts, 32'hFFFFFFFF, RESP_OKAY);
		// One-segment case runs to its end with all bits fed back
		decBitValid <= !fx;
		repeat (7040) @(posedge clock);
		decBitValid <= 1'b0;
		rd(REG_STATUS, {24'h0, fx, 1'b0, !fx, 5'h08},
			32'hA8, RESP_OKAY);
		$display("test decode done");
	endtask
	initial begin
		reset_n = 1'b0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready, frameStart, decBitValid} = '0;
		{decBit, symValid, okIn, foreignFrameUsed} = '0;
		{postScrambledFlag, dynamicRepeatFlag} = '0;
		s_axi_wstrb = 4'hF;
		dly = 4'h2;
		symIn = 24'h0;
		postCodeRateField = 3'h2;
		postModulationField = 4'h1;
		postFecLengthField = 2'h0;
		postInfoSizeField = '0;
		postTotalSizeField = 18'h02710;
		rfCount = 3'h0;
		pipeCount = 8'h00;
		auxCount = 4'h0;
		rst;
		rd(REG_CTRL, 32'h2, 32'hFFFFFFFF, RESP_OKAY);
		rd(8'h40, 32'h0, 32'hFFFFFFFF, RESP_SLVERR);
		wr(8'h40, 32'h3, r);
		chk("unmapped write resp", {30'h0, RESP_SLVERR}, {30'h0, r});
		rd(REG_STATUS, 32'h0, 32'hFF, RESP_OKAY);
		$display("test registers done");
		wr(REG_CTRL, 32'h3, r);
		wait (postFail === 1'b1);
		@(posedge clock);
		rd(REG_STATUS, 32'h14, 32'h1F, RESP_OKAY);
		$display("test pre failure done");
		okIn <= 1'b1;
		dec(18'h01B58, 3'h1, 8'h01, 4'h0, 1'b0,
			32'h1B780001, 32'h18380000, 32'h0077009F);
		// Reset after the first decode has finished, then a two-segment decode
		rst;
		dec(18'h036B0, 3'h2, 8'h02, 4'h1, 1'b1,
			32'h1B680002, 32'h2BB00010, 32'h00D7016E);
		give_verdict;
	end
	initial begin
		repeat (60000) @(posedge clock);
		n_mismatch++;
		give_verdict;
	end
endmodule
bind lsf_decode_ctrl lsf_decode_ctrl_checker chk_u (.*);
